// ### hw/scd_map.svh
// scd_map.svh: register offsets, field positions, reset values and counts
// for the system clock divider and source select block.
// assumes: included by bare name from design files; definitions only.
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

// register byte offsets on the bus
`define SCD_OFS_MODE      8'h00
`define SCD_OFS_SRC_CMD   8'h04
`define SCD_OFS_STATUS    8'h08

// clock_mode_register divider field
`define SCD_DIV_LSB       2
`define SCD_DIV_MSB       3
`define SCD_DIV_DEFAULT   2'h3

// source command bits
`define SCD_CMD_CERAMIC   0
`define SCD_CMD_RC        1

// status layout
`define SCD_ST_SRC_LSB    0
`define SCD_ST_DIV_LSB    2
`define SCD_ST_PHASE_LSB  4
`define SCD_ST_MCYC_LSB   16

// counts
`define SCD_INST_DIV      2'h3
`define SCD_RING_DIV      4'h4

`endif

// ### hw/scd_pkg.sv
// scd_pkg: types shared by the clock divider and source select block.
// assumes: compiled before every module that uses it.
package scd_pkg;

  // operation source currently driving the system clock
  typedef enum logic [1:0] {
    SCD_SRC_RING,
    SCD_SRC_CERAMIC,
    SCD_SRC_RC
  } scd_source_t;

endpackage

// ### hw/scd_sync.sv
// scd_sync: two-flop synchroniser with a rising-edge pulse on its output.
// assumes: i_async comes from a pin outside the i_clock domain.
`timescale 1ns/1ps
module scd_sync (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // first flop feeds only the second one
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edge detect on the synchronised level only
  assign o_level = sync_r;
  assign o_rise  = sync_r & ~prev_r;
endmodule

// ### hw/scd_clock_select.sv
// scd_clock_select: source selection, system clock divider and
// instruction clock generation, with an AHB-Lite register slave.
// assumes: one clock i_clock at 40 MHz; the oscillator pin is slow
// against it and is sampled; clocks are carried as one-cycle ticks.
//
// Contract
// - mode bits 3:2 divide the source by 1, 2, 4 or 8
// - reset and return from back-up load divide-by-8 default
// - instruction clock ticks once every three system clock ticks
// - each instruction clock period counts as one machine cycle
// - on-chip ring oscillator drives the system until software selects
// - ceramic op switches source to the oscillator input path
// - rc op switches source to the rc oscillator on that input
`timescale 1ns/1ps
`include "scd_map.svh"
module scd_clock_select (
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire logic               i_osc_in,
  input  wire logic               i_backup_return,
  input  wire logic               i_hsel,
  input  wire logic [31:0]        i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic      [31:0]        o_hrdata,
  output logic                    o_hreadyout,
  output logic                    o_hresp,
  output logic                    o_sys_tick,
  output logic                    o_inst_tick,
  output scd_pkg::scd_source_t    o_source,
  output logic      [1:0]         o_div_sel
);
  import scd_pkg::*;

  // bus state
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;
  // control and status state
  logic [1:0]  mode_div_r;
  logic [1:0]  act_div_r;
  scd_source_t source_r;
  logic [3:0]  ring_cnt_r;
  logic [2:0]  src_cnt_r;
  logic [1:0]  phase_r;
  logic [15:0] mcyc_r;
  logic        sys_tick_r;
  logic        inst_tick_r;

  // next values
  logic [1:0]  mode_div_nxt;
  logic [1:0]  act_div_nxt;
  scd_source_t source_nxt;
  logic [3:0]  ring_cnt_nxt;
  logic [2:0]  src_cnt_nxt;
  logic [1:0]  phase_nxt;
  logic [15:0] mcyc_nxt;

  // decode wires
  wire         addr_ph;
  wire         wr_mode;
  wire         wr_cmd;
  wire         osc_level;
  wire         osc_rise;
  wire         ring_tick;
  wire         src_tick;
  wire [2:0]   div_limit;
  wire         sys_tick;
  wire         inst_tick;
  wire [31:0]  rd_mux;
  wire [7:0]   rd_addr;
  logic        src_tick_sel;

  // oscillator pin passes two flops before use
  scd_sync u_osc_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (i_osc_in),
    .o_level (osc_level),
    .o_rise  (osc_rise)
  );

  // address phase and data phase write decode
  assign addr_ph = i_hsel & i_htrans[1] & i_hready;
  assign rd_addr = i_haddr[7:0];
  assign wr_mode = wr_pend_r & (wr_addr_r == `SCD_OFS_MODE);
  assign wr_cmd  = wr_pend_r & (wr_addr_r == `SCD_OFS_SRC_CMD);

  // read mux, sampled at the address phase; unmapped reads zero
  assign rd_mux =
    (rd_addr == `SCD_OFS_MODE)    ? {28'h0, mode_div_r, 2'h0} :
    (rd_addr == `SCD_OFS_SRC_CMD) ? {30'h0, source_r} :
    (rd_addr == `SCD_OFS_STATUS)  ? {mcyc_r, 10'h0, phase_r,
                                     act_div_r, source_r} :
    32'h0;

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0;
    end else begin
      wr_pend_r <= addr_ph & i_hwrite;
      wr_addr_r <= i_haddr[7:0];
      if (addr_ph & ~i_hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // mode field: back-up return loads default over a software write
  always_comb begin
    mode_div_nxt = mode_div_r;
    if (i_backup_return) begin
      mode_div_nxt = `SCD_DIV_DEFAULT;
    end else if (wr_mode) begin
      mode_div_nxt = i_hwdata[`SCD_DIV_MSB:`SCD_DIV_LSB];
    end
  end

  // source select: first op wins and then sticks until reset
  always_comb begin
    source_nxt = source_r;
    if (wr_cmd && source_r == SCD_SRC_RING) begin
      if (i_hwdata[`SCD_CMD_CERAMIC]) begin
        source_nxt = SCD_SRC_CERAMIC;
      end else if (i_hwdata[`SCD_CMD_RC]) begin
        source_nxt = SCD_SRC_RC;
      end
    end
  end

  // on-chip ring oscillator modelled as a free divider of i_clock
  assign ring_tick = (ring_cnt_r == (`SCD_RING_DIV - 4'h1));
  always_comb begin
    ring_cnt_nxt = ring_tick ? 4'h0 : ring_cnt_r + 4'h1;
  end

  // active source tick
  always_comb begin
    case (source_r)
      SCD_SRC_RING:    src_tick_sel = ring_tick;
      SCD_SRC_CERAMIC: src_tick_sel = osc_rise;
      SCD_SRC_RC:      src_tick_sel = osc_rise;
      default:         src_tick_sel = ring_tick;
    endcase
  end
  assign src_tick = src_tick_sel;

  // divider: limit is 2^n - 1, giving 2^n source ticks per system tick
  assign div_limit = (act_div_r == 2'h0) ? 3'h0 :
                     (act_div_r == 2'h1) ? 3'h1 :
                     (act_div_r == 2'h2) ? 3'h3 : 3'h7;
  assign sys_tick  = src_tick & (src_cnt_r >= div_limit);

  // new divider only taken at the end of a full period
  always_comb begin
    src_cnt_nxt = src_cnt_r;
    act_div_nxt = act_div_r;
    if (sys_tick) begin
      src_cnt_nxt = 3'h0;
      act_div_nxt = mode_div_r;
    end else if (src_tick) begin
      src_cnt_nxt = src_cnt_r + 3'h1;
    end
  end

  // instruction clock: one tick per three system ticks
  assign inst_tick = sys_tick & (phase_r == (`SCD_INST_DIV - 2'h1));
  always_comb begin
    phase_nxt = phase_r;
    mcyc_nxt  = mcyc_r;
    if (inst_tick) begin
      phase_nxt = 2'h0;
      mcyc_nxt  = mcyc_r + 16'h1;
    end else if (sys_tick) begin
      phase_nxt = phase_r + 2'h1;
    end
  end

  // control and timing state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_div_r  <= `SCD_DIV_DEFAULT;
      act_div_r   <= `SCD_DIV_DEFAULT;
      source_r    <= SCD_SRC_RING;
      ring_cnt_r  <= 4'h0;
      src_cnt_r   <= 3'h0;
      phase_r     <= 2'h0;
      mcyc_r      <= 16'h0;
      sys_tick_r  <= 1'b0;
      inst_tick_r <= 1'b0;
    end else begin
      mode_div_r  <= mode_div_nxt;
      act_div_r   <= act_div_nxt;
      source_r    <= source_nxt;
      ring_cnt_r  <= ring_cnt_nxt;
      src_cnt_r   <= src_cnt_nxt;
      phase_r     <= phase_nxt;
      mcyc_r      <= mcyc_nxt;
      sys_tick_r  <= sys_tick;
      inst_tick_r <= inst_tick;
    end
  end

  // outputs
  assign o_hrdata    = hrdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_sys_tick  = sys_tick_r;
  assign o_inst_tick = inst_tick_r;
  assign o_source    = source_r;
  assign o_div_sel   = act_div_r;

  // level output of the synchroniser is not needed beyond the edge
  wire unused_ok = osc_level | (|i_hsize);
endmodule

// ### sim/scd_clock_select_asserts.sv
// scd_clock_select_asserts: port checks for the clock select block.
// assumes: bound to the top; the ring source ticks every 4 clocks.
`timescale 1ns/1ps
module scd_clock_select_asserts
  import scd_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_backup_return,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_sys_tick,
  input wire logic        o_inst_tick,
  input wire scd_source_t o_source,
  input wire logic [1:0]  o_div_sel
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [5:0] gap_r;
  logic [3:0] seen_r;
  logic [1:0] nsys_r;
  // cycles since last tick, source and divider seen there, ticks per cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      gap_r  <= 6'h00;
      seen_r <= 4'hF;
      nsys_r <= 2'h0;
    end else begin
      gap_r  <= o_sys_tick ? 6'h00 : gap_r + 6'h01;
      seen_r <= o_sys_tick ? {o_source, o_div_sel} : seen_r;
      nsys_r <= !o_sys_tick ? nsys_r : o_inst_tick ? 2'h0 : nsys_r + 2'h1;
    end
  end
  sequence s_default;
    ##[1:40] o_div_sel == 2'h3;
  endsequence
  property p_bus_okay;
    o_hreadyout && !o_hresp;
  endproperty
  property p_inst_on_sys;
    o_inst_tick |-> o_sys_tick;
  endproperty
  property p_inst_third;
    o_sys_tick |-> o_inst_tick == (nsys_r == 2'h2);
  endproperty
  property p_period;
    o_sys_tick && o_source == SCD_SRC_RING && seen_r == {o_source, o_div_sel}
      |-> gap_r == (6'h04 << o_div_sel) - 6'h01;
  endproperty
  property p_reset_default;
    $past(i_rst) |-> o_div_sel == 2'h3 && o_source == SCD_SRC_RING;
  endproperty
  property p_backup;
    i_backup_return && o_source == SCD_SRC_RING |-> s_default;
  endproperty
  property p_src_sticky;
    o_source != SCD_SRC_RING |=> $stable(o_source);
  endproperty
  property p_div_on_tick;
    !$stable(o_div_sel) |-> $past(o_sys_tick) or ##[0:1] o_sys_tick;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus answer not ready and okay");
  a_inst_on_sys: assert property (p_inst_on_sys)
    else $error("instruction tick without system tick");
  a_inst_third: assert property (p_inst_third)
    else $error("instruction tick not on third system tick");
  a_period: assert property (p_period)
    else $error("system tick period wrong");
  a_reset_default: assert property (p_reset_default)
    else $error("reset state wrong");
  a_backup: assert property (p_backup)
    else $error("backup return left divider");
  a_src_sticky: assert property (p_src_sticky)
    else $error("source changed after selection");
  a_div_on_tick: assert property (p_div_on_tick)
    else $error("divider changed between ticks");
endmodule
bind scd_clock_select scd_clock_select_asserts i_chk (
  .i_clock(i_clock),
  .i_rst(i_rst),
  .i_backup_return(i_backup_return),
  .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp),
  .o_sys_tick(o_sys_tick),
  .o_inst_tick(o_inst_tick),
  .o_source(o_source),
  .o_div_sel(o_div_sel)
);

// ### sim/scd_osc_model.sv
// scd_osc_model: external oscillator on the oscillator input pin.
// assumes: rests low while disabled; phase unrelated to the bench clock.
`timescale 1ns/1ps
module scd_osc_model #(
  parameter int HALF_NS = 150
) (
  input  wire logic i_enable,
  output logic      o_osc
);
  // toggle each half period while enabled
  initial begin
    o_osc = 1'b0;
    #7;
    forever begin
      #(HALF_NS);
      o_osc = i_enable ? ~o_osc : 1'b0;
    end
  end
endmodule

// ### sim/system_clock_divider_select_tb.sv
// system_clock_divider_select_tb: bus driven checks of the clock select.
// assumes: zero wait slave; oscillator period 300 ns, 12 clocks.
`timescale 1ns/1ps
`include "scd_map.svh"
module system_clock_divider_select_tb;
  import scd_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_rst, i_backup_return, i_hwrite, osc_en, osc;
  logic        o_hreadyout, o_hresp, o_sys_tick, o_inst_tick;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd, st;
  logic [1:0]  i_htrans, o_div_sel;
  scd_source_t o_source;
  int          err_count, tests_run, per;
  always #12.5 i_clock = ~i_clock;
  scd_osc_model i_osc (.i_enable(osc_en), .o_osc(osc));
  scd_clock_select i_dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_osc_in(osc), .i_backup_return(i_backup_return), .i_hsel(1'b1),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_sys_tick(o_sys_tick), .o_inst_tick(o_inst_tick),
    .o_source(o_source), .o_div_sel(o_div_sel));
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // wait edges until the picked output (1: sys tick, 0: ready) is high
  task automatic upto(input bit tick, input int lim, output int n);
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while ((tick ? o_sys_tick : o_hreadyout) !== 1'b1 && n < lim);
    if ((tick ? o_sys_tick : o_hreadyout) !== 1'b1) begin
      chk(32'h0, 32'h1);
      print_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    i_htrans <= 2'h2;
    i_haddr  <= {24'h0, a};
    i_hwrite <= w;
    upto(1'b0, 50, n);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    upto(1'b0, 50, n);
    q = o_hrdata;
  endtask
  task automatic span(output int p);
    upto(1'b1, 400, p);
    upto(1'b1, 400, p);
    upto(1'b1, 400, p);
  endtask
  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
  endtask
  // main sequence
  initial begin
    {i_rst, i_backup_return, i_hwrite, osc_en, i_htrans} = 6'h20;
    {i_haddr, i_hwdata, err_count, tests_run} = '0;
    do_reset();
    bus(0, `SCD_OFS_MODE, 32'h0, rd);
    chk(rd, 32'h0000000C);
    bus(0, `SCD_OFS_STATUS, 32'h0, st);
    chk({28'h0, st[3:0]}, 32'h0000000C);
    span(per);
    chk(per, 32'd32);
    bus(0, `SCD_OFS_STATUS, 32'h0, rd);
    chk({16'h0, rd[31:16] - st[31:16]}, 32'h1);
    for (int d = 0; d < 4; d++) begin
      bus(1, `SCD_OFS_MODE, 32'(d << 2), rd);
      span(per);
      chk(per, 32'(4 << d));
    end
    bus(1, 8'h10, 32'hFFFFFFFF, rd);
    bus(0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1, `SCD_OFS_MODE, 32'h0, rd);
    span(per);
    chk(per, 32'd4);
    i_backup_return <= 1'b1;
    @(posedge i_clock);
    i_backup_return <= 1'b0;
    bus(0, `SCD_OFS_MODE, 32'h0, rd);
    chk(rd, 32'h0000000C);
    span(per);
    chk(per, 32'd32);
    osc_en <= 1'b1;
    bus(1, `SCD_OFS_SRC_CMD, 32'h2, rd);
    bus(1, `SCD_OFS_SRC_CMD, 32'h1, rd);
    bus(0, `SCD_OFS_SRC_CMD, 32'h0, rd);
    chk(rd, 32'(SCD_SRC_RC));
    bus(1, `SCD_OFS_MODE, 32'h0, rd);
    span(per);
    chk(per, 32'd12);
    do_reset();
    bus(1, `SCD_OFS_SRC_CMD, 32'h3, rd);
    bus(1, `SCD_OFS_MODE, 32'h4, rd);
    bus(0, `SCD_OFS_SRC_CMD, 32'h0, rd);
    chk(rd, 32'(SCD_SRC_CERAMIC));
    span(per);
    chk(per, 32'd24);
    print_verdict();
  end
endmodule
